// ### hw/rse_pkg.sv
// rotate / skip / return execution slice: shared constants and types
// assumes one 50 MHz core clock and a decoder that presents one opcode at a time
package rse_pkg;

  // ----------------------------------------------------------------
  // opcodes of the slice
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NONE,
    OP_SUBROUTINE_EXIT,
    OP_EXIT_WITH_LITERAL,
    OP_INTERRUPT_EXIT,
    OP_ROTATE_LEFT,
    OP_ROTATE_LEFT_TO_WORK,
    OP_ROTATE_LEFT_WRAP,
    OP_ROTATE_LEFT_WRAP_TO_WORK,
    OP_ROTATE_RIGHT,
    OP_ROTATE_RIGHT_TO_WORK,
    OP_ROTATE_RIGHT_WRAP,
    OP_ROTATE_RIGHT_WRAP_TO_WORK,
    OP_SUBTRACT_WITH_BORROW,
    OP_SUBTRACT_WITH_BORROW_TO_MEM,
    OP_DECREMENT_SKIP_IF_NULL,
    OP_DECREMENT_SKIP_TO_WORK,
    OP_INCREMENT_SKIP_IF_NULL,
    OP_INCREMENT_SKIP_TO_WORK,
    OP_BIT_SKIP_IF_ONE,
    OP_SET_BYTE,
    OP_SET_BIT
  } rse_op_t;

  // sequencer: idle or inserting the dummy cycle
  typedef enum logic [0:0] {
    ST_IDLE,
    ST_DUMMY
  } rse_state_t;

  // ----------------------------------------------------------------
  // register port map and field positions
  // ----------------------------------------------------------------
  localparam int         REG_AW      = 2;
  localparam logic [1:0] REG_STATUS  = 2'h0;
  localparam logic [1:0] REG_WORK    = 2'h1;
  localparam logic [1:0] REG_CTRL    = 2'h2;
  localparam logic [1:0] REG_STACK   = 2'h3;
  localparam int         FLD_WRAP    = 0;
  localparam int         FLD_HALF    = 1;
  localparam int         FLD_NULL    = 2;
  localparam int         FLD_SIGNED  = 3;
  localparam int         FLD_MIE     = 0;
  localparam logic [7:0] RST_WORK    = 8'h00;
  localparam logic [7:0] BYTE_ONES   = 8'hFF;
  localparam logic [7:0] BYTE_ONE    = 8'h01;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  // cycles per instruction, counted in core clocks
  localparam int RETURN_CYCLES   = 2;
  localparam int SKIP_CYCLES     = 2;
  localparam int NOSKIP_CYCLES   = 1;

endpackage

// ### hw/rse_exec.sv
// rotate / skip / return execution slice of an 8-bit core
// assumes the decoder holds opcode and operands while exec_valid is high, and that
// mem_rdata already shows the addressed byte in that same cycle
//
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps

// Summary of operation
// RL1: subroutine_exit pops pc, two cycles, flags kept
// RL2: exit_with_literal pops pc, loads literal into work
// RL3: interrupt_exit pops pc, sets master_irq_enable
// RL4: rotate_left rotates memory byte, writes memory back
// RL5: rotate_left_to_work puts left rotation into work
// RL6: rotate_left_wrap rotates through wrap bit into memory
// RL7: rotate_left_wrap_to_work: same rotation into work
// RL8: rotate_right rotates memory byte, writes memory back
// RL9: rotate_right_to_work puts right rotation into work
// RL10: rotate_right_wrap rotates through wrap bit into memory
// RL11: rotate_right_wrap_to_work: same rotation into work
// RL12: subtract_with_borrow: work plus inverted byte plus wrap
// RL13: subtract_with_borrow_to_mem: same, result to memory
// RL14: taken skip flushes prefetch, two cycles; else one
// RL15: decrement_skip_if_null writes byte minus one, skips zero
// RL16: decrement_skip_to_work puts byte minus one in work
// RL17: increment_skip_if_null writes byte plus one, skips zero
// RL18: increment_skip_to_work puts byte plus one in work
// RL19: bit_skip_if_one skips when selected bit is one
// RL20: set byte writes all ones, flags kept
// RL21: set bit forces only selected bit high
// RL22: return stack is parameterised push/pop store
module rse_exec #(
  parameter int PC_W  = 11,
  parameter int DEPTH = 4,
  parameter int ADR_W = 7
) (
  input  wire logic                       clk,
  input  wire logic                       rst_n,
  input  wire logic                       exec_valid,
  input  rse_pkg::rse_op_t                exec_op,
  input  wire logic [ADR_W-1:0]           mem_addr,
  input  wire logic [2:0]                 bit_sel,
  input  wire logic [7:0]                 literal,
  input  wire logic [7:0]                 mem_rdata,
  input  wire logic                       call_push,
  input  wire logic [PC_W-1:0]            call_pc,
  input  wire logic [rse_pkg::REG_AW-1:0] reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic [7:0]                      reg_rdata,
  output logic                            exec_ready,
  output logic                            pc_load,
  output logic [PC_W-1:0]                 pc_value,
  output logic                            skip_flush,
  output logic                            mem_we,
  output logic [ADR_W-1:0]                mem_waddr,
  output logic [7:0]                      mem_wdata,
  output logic [7:0]                      work_reg,
  output logic                            wrap_out_bit,
  output logic                            half_carry_flag,
  output logic                            result_null_flag,
  output logic                            signed_wrap_flag,
  output logic                            master_irq_enable
);
  import rse_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam int SP_W  = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  typedef struct packed {
    rse_state_t                 state;
    logic [7:0]                 work;
    logic                       wrap;
    logic                       half;
    logic                       nul;
    logic                       sgn;
    logic                       mie;
    logic [DEPTH-1:0][PC_W-1:0] stk;
    logic [SP_W-1:0]            sp;
    logic [CNT_W-1:0]           cnt;
    logic                       pc_load;
    logic [PC_W-1:0]            pc_val;
    logic                       skip;
    logic                       mem_we;
    logic [ADR_W-1:0]           waddr;
    logic [7:0]                 wdata;
    logic [7:0]                 rdata;
  } rse_exec_st_t;

  rse_exec_st_t st_reg;
  rse_exec_st_t st_next;

  logic            take;
  logic [7:0]      rol;
  logic [7:0]      rolw;
  logic [7:0]      ror;
  logic [7:0]      rorw;
  logic [8:0]      sbc_sum;
  logic [4:0]      sbc_low;
  logic [7:0]      sbc_res;
  logic            sbc_ovf;
  logic [7:0]      dec_val;
  logic [7:0]      inc_val;
  logic [7:0]      bit_mask;
  logic [SP_W-1:0] sp_top;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // an op is taken only while no dummy cycle is pending
  assign take = exec_valid && (st_reg.state == ST_IDLE);

  // rotations; the wrap forms carry nine bits through wrap_out_bit
  assign rol  = {mem_rdata[6:0], mem_rdata[7]};    // see RL4
  assign rolw = {mem_rdata[6:0], st_reg.wrap};     // see RL6
  assign ror  = {mem_rdata[0], mem_rdata[7:1]};    // see RL8
  assign rorw = {st_reg.wrap, mem_rdata[7:1]};     // see RL10

  // borrow-aware subtract: work + ~m + wrap, flags from this adder except half carry from sbc_low
  assign sbc_sum = {1'b0, st_reg.work} + {1'b0, ~mem_rdata} + {8'h00, st_reg.wrap};       // see RL12
  assign sbc_low = {1'b0, st_reg.work[3:0]} + {1'b0, ~mem_rdata[3:0]} + {4'h0, st_reg.wrap};
  assign sbc_res = sbc_sum[7:0];
  assign sbc_ovf = (st_reg.work[7] == ~mem_rdata[7]) && (sbc_res[7] != st_reg.work[7]);

  // skip-group arithmetic wraps modulo 256
  assign dec_val  = mem_rdata - BYTE_ONE;
  assign inc_val  = mem_rdata + BYTE_ONE;
  assign bit_mask = BYTE_ONE << bit_sel;

  // the newest entry sits one below the pointer; the pointer wraps like a ring
  assign sp_top = st_reg.sp - SP_W'(1);           // see RL22

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_next         = st_reg;
    st_next.pc_load = 1'b0;
    st_next.skip    = 1'b0;
    st_next.mem_we  = 1'b0;
    st_next.rdata   = BYTE_ZERO;
    if (st_reg.state == ST_DUMMY) begin
      st_next.state = ST_IDLE;
    end

    // software writes go first so that an instruction in the same cycle wins
    if (reg_wr) begin
      unique case (reg_addr)
        REG_STATUS: begin
          st_next.wrap = reg_wdata[FLD_WRAP];
          st_next.half = reg_wdata[FLD_HALF];
          st_next.nul  = reg_wdata[FLD_NULL];
          st_next.sgn  = reg_wdata[FLD_SIGNED];
        end
        REG_WORK: st_next.work = reg_wdata;
        REG_CTRL: st_next.mie  = reg_wdata[FLD_MIE];
        REG_STACK: begin
        end
      endcase
    end

    // read data stands only in the cycle after the strobe
    if (reg_rd) begin
      unique case (reg_addr)
        REG_STATUS: st_next.rdata = {4'h0, st_reg.sgn, st_reg.nul, st_reg.half, st_reg.wrap};
        REG_WORK:   st_next.rdata = st_reg.work;
        REG_CTRL:   st_next.rdata = {7'h00, st_reg.mie};
        REG_STACK:  st_next.rdata = 8'(st_reg.cnt);
      endcase
    end

    // call pushes from the core; a pop in the same cycle takes precedence
    if (call_push && !(take && (exec_op inside {OP_SUBROUTINE_EXIT, OP_EXIT_WITH_LITERAL, OP_INTERRUPT_EXIT}))) begin
      st_next.stk[st_reg.sp] = call_pc;            // see RL22
      st_next.sp             = st_reg.sp + SP_W'(1);
      if (st_reg.cnt != CNT_W'(DEPTH)) begin
        st_next.cnt = st_reg.cnt + CNT_W'(1);
      end
    end

    if (take) begin
      st_next.waddr = mem_addr;
      unique case (exec_op)
        // returns: pop, reload pc, then one dummy cycle; flags untouched
        OP_SUBROUTINE_EXIT, OP_EXIT_WITH_LITERAL, OP_INTERRUPT_EXIT: begin
          st_next.pc_load = 1'b1;                  // see RL1
          st_next.pc_val  = st_reg.stk[sp_top];
          st_next.sp      = sp_top;
          st_next.state   = ST_DUMMY;
          if (st_reg.cnt != CNT_W'(0)) begin
            st_next.cnt = st_reg.cnt - CNT_W'(1);
          end
          if (exec_op == OP_EXIT_WITH_LITERAL) begin
            st_next.work = literal;                // see RL2
          end
          if (exec_op == OP_INTERRUPT_EXIT) begin
            st_next.mie = 1'b1;                    // see RL3
          end
        end
        OP_ROTATE_LEFT: begin
          st_next.mem_we = 1'b1;                   // see RL4
          st_next.wdata  = rol;
        end
        OP_ROTATE_LEFT_TO_WORK: begin
          st_next.work = rol;                      // see RL5
        end
        OP_ROTATE_LEFT_WRAP: begin
          st_next.mem_we = 1'b1;                   // see RL6
          st_next.wdata  = rolw;
          st_next.wrap   = mem_rdata[7];
        end
        OP_ROTATE_LEFT_WRAP_TO_WORK: begin
          st_next.work = rolw;                     // see RL7
          st_next.wrap = mem_rdata[7];
        end
        OP_ROTATE_RIGHT: begin
          st_next.mem_we = 1'b1;                   // see RL8
          st_next.wdata  = ror;
        end
        OP_ROTATE_RIGHT_TO_WORK: begin
          st_next.work = ror;                      // see RL9
        end
        OP_ROTATE_RIGHT_WRAP: begin
          st_next.mem_we = 1'b1;                   // see RL10
          st_next.wdata  = rorw;
          st_next.wrap   = mem_rdata[0];
        end
        OP_ROTATE_RIGHT_WRAP_TO_WORK: begin
          st_next.work = rorw;                     // see RL11
          st_next.wrap = mem_rdata[0];
        end
        OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
          st_next.wrap = sbc_sum[8];               // see RL12
          st_next.half = sbc_low[4];
          st_next.nul  = (sbc_res == BYTE_ZERO);
          st_next.sgn  = sbc_ovf;
          if (exec_op == OP_SUBTRACT_WITH_BORROW) begin
            st_next.work = sbc_res;
          end else begin
            st_next.mem_we = 1'b1;                 // see RL13
            st_next.wdata  = sbc_res;
          end
        end
        OP_DECREMENT_SKIP_IF_NULL: begin
          st_next.mem_we = 1'b1;                   // see RL15
          st_next.wdata  = dec_val;
          st_next.skip   = (dec_val == BYTE_ZERO);
        end
        OP_DECREMENT_SKIP_TO_WORK: begin
          st_next.work = dec_val;                  // see RL16
          st_next.skip = (dec_val == BYTE_ZERO);
        end
        OP_INCREMENT_SKIP_IF_NULL: begin
          st_next.mem_we = 1'b1;                   // see RL17
          st_next.wdata  = inc_val;
          st_next.skip   = (inc_val == BYTE_ZERO);
        end
        OP_INCREMENT_SKIP_TO_WORK: begin
          st_next.work = inc_val;                  // see RL18
          st_next.skip = (inc_val == BYTE_ZERO);
        end
        OP_BIT_SKIP_IF_ONE: begin
          st_next.skip = mem_rdata[bit_sel];       // see RL19
        end
        OP_SET_BYTE: begin
          st_next.mem_we = 1'b1;                   // see RL20
          st_next.wdata  = BYTE_ONES;
        end
        OP_SET_BIT: begin
          st_next.mem_we = 1'b1;                   // see RL21
          st_next.wdata  = mem_rdata | bit_mask;
        end
        default: begin
        end
      endcase
      // a taken skip discards the prefetched word and costs a dummy cycle
      if (st_next.skip) begin
        st_next.state = ST_DUMMY;                  // see RL14
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  // stack contents are cleared too, so a pop before any push returns zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg       <= '0;
      st_reg.state <= ST_IDLE;
      st_reg.work  <= RST_WORK;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign exec_ready        = (st_reg.state == ST_IDLE);
  assign pc_load           = st_reg.pc_load;
  assign pc_value          = st_reg.pc_val;
  assign skip_flush        = st_reg.skip;
  assign mem_we            = st_reg.mem_we;
  assign mem_waddr         = st_reg.waddr;
  assign mem_wdata         = st_reg.wdata;
  assign work_reg          = st_reg.work;
  assign wrap_out_bit      = st_reg.wrap;
  assign half_carry_flag   = st_reg.half;
  assign result_null_flag  = st_reg.nul;
  assign signed_wrap_flag  = st_reg.sgn;
  assign master_irq_enable = st_reg.mie;
  assign reg_rdata         = st_reg.rdata;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_take(rse_op_t o);
    take && (exec_op == o);
  endsequence

  // returns reload the pc, stall one cycle, then accept again
  sequence s_return_body;
    pc_load && !exec_ready ##1 exec_ready && !pc_load;
  endsequence

  // a taken skip flushes once and is followed by a free cycle
  sequence s_skip_body;
    skip_flush && !exec_ready ##1 exec_ready && !skip_flush;
  endsequence

  ret_two_cycle_a: assert property (  // see RL1
    s_take(OP_SUBROUTINE_EXIT) ##0 !reg_wr |=> s_return_body and $stable({wrap_out_bit, half_carry_flag,
      result_null_flag, signed_wrap_flag}))
    else $error("subroutine exit timing or flags wrong");

  lit_load_a: assert property (  // see RL2
    s_take(OP_EXIT_WITH_LITERAL) |=> pc_load && (work_reg == $past(literal)))
    else $error("literal not loaded on exit");

  irq_reenable_a: assert property (  // see RL3
    s_take(OP_INTERRUPT_EXIT) |=> master_irq_enable && pc_load ##1 master_irq_enable || $past(reg_wr))
    else $error("interrupt exit did not enable interrupts");

  rol_mem_a: assert property (  // see RL4
    s_take(OP_ROTATE_LEFT) |=> mem_we && (mem_wdata == {$past(mem_rdata[6:0]), $past(mem_rdata[7])}))
    else $error("left rotate result wrong");

  rol_wrap_a: assert property (  // see RL6
    s_take(OP_ROTATE_LEFT_WRAP) |=> mem_we && (mem_wdata == {$past(mem_rdata[6:0]), $past(wrap_out_bit)})
      && (wrap_out_bit == $past(mem_rdata[7])))
    else $error("left wrap rotate wrong");

  ror_work_a: assert property (  // see RL9
    s_take(OP_ROTATE_RIGHT_TO_WORK) |=> !mem_we && (work_reg == {$past(mem_rdata[0]), $past(mem_rdata[7:1])}))
    else $error("right rotate to work wrong");

  sbc_result_a: assert property (  // see RL12
    s_take(OP_SUBTRACT_WITH_BORROW) |=> (work_reg == 8'($past(work_reg) - $past(mem_rdata)
      - {7'h00, !$past(wrap_out_bit)})) && (result_null_flag == (work_reg == BYTE_ZERO)))
    else $error("subtract with borrow wrong");

  skip_len_a: assert property (  // see RL14
    take && !(exec_op inside {OP_SUBROUTINE_EXIT, OP_EXIT_WITH_LITERAL, OP_INTERRUPT_EXIT}) |=>
      (skip_flush ##0 s_skip_body) or (!skip_flush && exec_ready))
    else $error("skip cycle count wrong");

  dec_skip_a: assert property (  // see RL15
    s_take(OP_DECREMENT_SKIP_IF_NULL) ##0 (mem_rdata == BYTE_ONE) |=> skip_flush && mem_we
      && (mem_wdata == BYTE_ZERO))
    else $error("decrement to zero did not skip");

  set_bit_a: assert property (  // see RL21
    s_take(OP_SET_BIT) |=> mem_we && mem_wdata[$past(bit_sel)]
      && ((mem_wdata & ~(BYTE_ONE << $past(bit_sel))) == ($past(mem_rdata) & ~(BYTE_ONE << $past(bit_sel)))))
    else $error("set bit disturbed other bits");

endmodule

// ### verification/rse_exec_tb_top.sv
// self-checking bench for the rotate / skip / return execution slice
// assumes rse_pkg is compiled first; the bench plays decoder, data memory, caller and register master
`timescale 1ns/1ps

`define RSE_CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end

module rse_exec_tb_top;
  import rse_pkg::*;

  // ----------------------------------------------------------------
  // parameters and signals
  // ----------------------------------------------------------------
  localparam int PC_W  = 11;
  localparam int DEPTH = 4;
  localparam int ADR_W = 7;
  localparam int LIMIT = 20000;  // the whole run needs about a thousand cycles

  logic                clk;
  logic                rst_n;
  logic                exec_valid;
  rse_op_t             exec_op;
  logic [ADR_W-1:0]    mem_addr;
  logic [2:0]          bit_sel;
  logic [7:0]          literal;
  logic [7:0]          mem_rdata;
  logic                call_push;
  logic [PC_W-1:0]     call_pc;
  logic [REG_AW-1:0]   reg_addr;
  logic [7:0]          reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [7:0]          reg_rdata;
  logic                exec_ready;
  logic                pc_load;
  logic [PC_W-1:0]     pc_value;
  logic                skip_flush;
  logic                mem_we;
  logic [ADR_W-1:0]    mem_waddr;
  logic [7:0]          mem_wdata;
  logic [7:0]          work_reg;
  logic                wrap_out_bit;
  logic                half_carry_flag;
  logic                result_null_flag;
  logic                signed_wrap_flag;
  logic                master_irq_enable;
  int                  n_fail;
  int                  checks;
  int                  cycles;
  logic [7:0]          ew;             // expected working register
  logic                ec, eh, ez, ev, emie;
  logic [PC_W-1:0]     stk[$];         // expected return stack, top at the back
  logic [7:0]          rd;

  rse_exec #(.PC_W(PC_W), .DEPTH(DEPTH), .ADR_W(ADR_W)) i_rse_exec (
    .clk(clk), .rst_n(rst_n), .exec_valid(exec_valid), .exec_op(exec_op), .mem_addr(mem_addr),
    .bit_sel(bit_sel), .literal(literal), .mem_rdata(mem_rdata), .call_push(call_push),
    .call_pc(call_pc), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .exec_ready(exec_ready), .pc_load(pc_load), .pc_value(pc_value),
    .skip_flush(skip_flush), .mem_we(mem_we), .mem_waddr(mem_waddr), .mem_wdata(mem_wdata),
    .work_reg(work_reg), .wrap_out_bit(wrap_out_bit), .half_carry_flag(half_carry_flag),
    .result_null_flag(result_null_flag), .signed_wrap_flag(signed_wrap_flag),
    .master_irq_enable(master_irq_enable));

  // ----------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------
  initial clk = 1'b0;
  always #10 clk = ~clk;

  // a stuck handshake would otherwise spin forever
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_fail++;
      complete_run();
    end
  end

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // one-cycle write strobe; status and work writes keep the model in step
  task automatic reg_write(input logic [REG_AW-1:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0; reg_wdata <= ~d;
    if (a == REG_STATUS) {ev, ez, eh, ec} = d[3:0];
    if (a == REG_WORK) ew = d;
    if (a == REG_CTRL) emie = d[FLD_MIE];
  endtask

  // read data is looked at in the one cycle after the strobe
  task automatic reg_read(input logic [REG_AW-1:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic push_pc(input logic [PC_W-1:0] p);
    @(posedge clk);
    call_push <= 1'b1; call_pc <= p;
    @(posedge clk);
    call_push <= 1'b0; call_pc <= ~p;
    stk.push_back(p);
  endtask

  // present one opcode, work out the expected result, compare the cycle after it is taken
  task automatic run_op(input rse_op_t op, input logic [7:0] m, input logic [2:0] b, input logic [7:0] lit);
    logic [8:0]       s;
    logic [4:0]       hs;
    logic [7:0]       r;
    logic             sk, ret, we;
    logic [PC_W-1:0]  pc;
    logic [ADR_W-1:0] a;
    r = m; sk = 1'b0; ret = 1'b0; pc = '0; a = ADR_W'($urandom);
    case (op)
      OP_SUBROUTINE_EXIT, OP_EXIT_WITH_LITERAL, OP_INTERRUPT_EXIT: begin
        ret = 1'b1;
        pc = stk.pop_back();
        if (op == OP_EXIT_WITH_LITERAL) ew = lit;
        if (op == OP_INTERRUPT_EXIT) emie = 1'b1;
      end
      OP_ROTATE_LEFT, OP_ROTATE_LEFT_TO_WORK: r = {m[6:0], m[7]};
      OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_TO_WORK: r = {m[0], m[7:1]};
      OP_ROTATE_LEFT_WRAP, OP_ROTATE_LEFT_WRAP_TO_WORK: begin
        r = {m[6:0], ec};
        ec = m[7];
      end
      OP_ROTATE_RIGHT_WRAP, OP_ROTATE_RIGHT_WRAP_TO_WORK: begin
        r = {ec, m[7:1]};
        ec = m[0];
      end
      OP_SUBTRACT_WITH_BORROW, OP_SUBTRACT_WITH_BORROW_TO_MEM: begin
        s = {1'b0, ew} + {1'b0, ~m} + {8'h00, ec};
        hs = {1'b0, ew[3:0]} + {1'b0, ~m[3:0]} + {4'h0, ec};
        r = s[7:0];
        ev = (ew[7] == ~m[7]) && (r[7] != ew[7]);
        ez = (r == BYTE_ZERO); eh = hs[4]; ec = s[8];
      end
      OP_DECREMENT_SKIP_IF_NULL, OP_DECREMENT_SKIP_TO_WORK: r = m - BYTE_ONE;
      OP_INCREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_TO_WORK: r = m + BYTE_ONE;
      OP_BIT_SKIP_IF_ONE: sk = m[b];
      OP_SET_BYTE: r = BYTE_ONES;
      OP_SET_BIT: r[b] = 1'b1;
      default: r = m;
    endcase
    if (op inside {OP_DECREMENT_SKIP_IF_NULL, OP_DECREMENT_SKIP_TO_WORK, OP_INCREMENT_SKIP_IF_NULL,
                   OP_INCREMENT_SKIP_TO_WORK}) sk = (r == BYTE_ZERO);
    we = op inside {OP_ROTATE_LEFT, OP_ROTATE_LEFT_WRAP, OP_ROTATE_RIGHT, OP_ROTATE_RIGHT_WRAP,
                    OP_SUBTRACT_WITH_BORROW_TO_MEM, OP_DECREMENT_SKIP_IF_NULL, OP_INCREMENT_SKIP_IF_NULL,
                    OP_SET_BYTE, OP_SET_BIT};
    if (op inside {OP_ROTATE_LEFT_TO_WORK, OP_ROTATE_LEFT_WRAP_TO_WORK, OP_ROTATE_RIGHT_TO_WORK,
                   OP_ROTATE_RIGHT_WRAP_TO_WORK, OP_SUBTRACT_WITH_BORROW, OP_DECREMENT_SKIP_TO_WORK,
                   OP_INCREMENT_SKIP_TO_WORK}) ew = r;
    @(posedge clk);
    exec_valid <= 1'b1; exec_op <= op; mem_addr <= a; bit_sel <= b; literal <= lit; mem_rdata <= m;
    @(posedge clk);
    exec_valid <= 1'b0; exec_op <= OP_NONE; mem_rdata <= ~m; literal <= ~lit;
    #1;
    `RSE_CHK(mem_we, we)
    if (we) `RSE_CHK({mem_waddr, mem_wdata}, {a, r})
    `RSE_CHK(work_reg, ew)
    `RSE_CHK({signed_wrap_flag, result_null_flag, half_carry_flag, wrap_out_bit}, {ev, ez, eh, ec})
    `RSE_CHK(master_irq_enable, emie)
    `RSE_CHK({pc_load, skip_flush, exec_ready}, {ret, sk, ~(sk | ret)})
    if (ret) `RSE_CHK(pc_value, pc)
    if (sk | ret) begin
      @(posedge clk);
      #1 `RSE_CHK({pc_load, skip_flush, exec_ready}, 3'b001)
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_n = 1'b0; exec_valid = 1'b0; exec_op = OP_NONE; mem_addr = '0; bit_sel = 3'h0;
    literal = 8'h00; mem_rdata = 8'h00; call_push = 1'b0; call_pc = '0; reg_addr = '0;
    reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; n_fail = 0; checks = 0; cycles = 0;
    ew = RST_WORK; {ec, eh, ez, ev, emie} = 5'h00;
    void'($urandom(32'h6117896f));
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;

    // registers come up cleared; the depth count is read-only
    for (int i = 0; i < 4; i++) begin
      reg_read(REG_AW'(i), rd);
      `RSE_CHK(rd, 8'h00)
    end
    reg_write(REG_STACK, 8'hA5);
    reg_read(REG_STACK, rd);
    `RSE_CHK(rd, 8'h00)
    $display("test reset_regs done");

    // three calls then three different returns, flags preset so any disturbance shows
    for (int i = 0; i < 3; i++) push_pc(PC_W'($urandom));
    reg_read(REG_STACK, rd);
    `RSE_CHK(rd, 8'h03)
    reg_write(REG_STATUS, 8'($urandom) & 8'h0F);
    run_op(OP_SUBROUTINE_EXIT, 8'($urandom), 3'h0, 8'h00);
    run_op(OP_EXIT_WITH_LITERAL, 8'($urandom), 3'h0, 8'($urandom));
    reg_write(REG_CTRL, 8'h00);
    run_op(OP_INTERRUPT_EXIT, 8'($urandom), 3'h0, 8'($urandom));
    $display("test returns done");

    // boundary values: wrap to zero, skip edges, bit ends, overflow in subtract
    run_op(OP_DECREMENT_SKIP_IF_NULL, 8'h01, 3'h0, 8'h00);
    run_op(OP_DECREMENT_SKIP_IF_NULL, 8'h00, 3'h0, 8'h00);
    run_op(OP_DECREMENT_SKIP_TO_WORK, 8'h01, 3'h0, 8'h00);
    run_op(OP_INCREMENT_SKIP_IF_NULL, 8'hFF, 3'h0, 8'h00);
    run_op(OP_INCREMENT_SKIP_IF_NULL, 8'h7F, 3'h0, 8'h00);
    run_op(OP_INCREMENT_SKIP_TO_WORK, 8'hFF, 3'h0, 8'h00);
    run_op(OP_BIT_SKIP_IF_ONE, 8'h80, 3'h7, 8'h00);
    run_op(OP_BIT_SKIP_IF_ONE, 8'hFE, 3'h0, 8'h00);
    run_op(OP_SET_BIT, 8'h00, 3'h3, 8'h00);
    run_op(OP_SET_BYTE, 8'h12, 3'h0, 8'h00);
    for (int o = OP_ROTATE_LEFT; o <= OP_ROTATE_RIGHT_WRAP_TO_WORK; o++) run_op(rse_op_t'(o), 8'h81, 3'h0, 8'h00);
    reg_write(REG_WORK, 8'h80);
    reg_write(REG_STATUS, 8'h01);
    run_op(OP_SUBTRACT_WITH_BORROW, 8'h01, 3'h0, 8'h00);
    run_op(OP_SUBTRACT_WITH_BORROW_TO_MEM, 8'h7F, 3'h0, 8'h00);
    $display("test corners done");

    // random opcodes and operands, with flag and work preloads through the register port
    for (int n = 0; n < 300; n++) begin
      if ($urandom % 4 == 0) reg_write(REG_STATUS, 8'($urandom) & 8'h0F);
      if ($urandom % 4 == 0) reg_write(REG_WORK, 8'($urandom));
      run_op(rse_op_t'(OP_ROTATE_LEFT + ($urandom % 17)), 8'($urandom), 3'($urandom), 8'($urandom));
    end
    reg_read(REG_STATUS, rd);
    `RSE_CHK(rd, {4'h0, ev, ez, eh, ec})
    reg_read(REG_WORK, rd);
    `RSE_CHK(rd, ew)
    $display("test random done");
    complete_run();
  end

endmodule
